// ---- shared/supervisor_pkg.sv ----
package supervisor_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 24;

    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_TIMEOUT   = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_FEED      = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT     = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_WARNING   = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_WINDOW    = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_MASK      = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_RST_CAUSE = 6'h20;

    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned CTRL_RST_SEL_BIT = 1;
    localparam int unsigned CTRL_WIN_EN_BIT  = 2;

    localparam int unsigned STAT_W           = 3;
    localparam int unsigned STAT_TIMEOUT_BIT = 0;
    localparam int unsigned STAT_WARNING_BIT = 1;
    localparam int unsigned STAT_FEED_BIT    = 2;

    localparam logic [DATA_W-1:0] FEED_KEY_FIRST  = 32'h0000_00AA;
    localparam logic [DATA_W-1:0] FEED_KEY_SECOND = 32'h0000_0055;

    localparam logic [CNT_W-1:0] TIMEOUT_MIN   = 24'h00_00FF;
    localparam logic [CNT_W-1:0] TIMEOUT_RESET = 24'hFF_FFFF;
    localparam logic [CNT_W-1:0] WARNING_RESET = 24'h00_0000;
    localparam logic [CNT_W-1:0] WINDOW_RESET  = 24'hFF_FFFF;

    localparam int unsigned PRE_W = 2;
    localparam logic [PRE_W-1:0] PRESCALE_LAST = 2'h3;

    localparam int unsigned RST_PULSE_W = 4;
    localparam logic [RST_PULSE_W-1:0] RST_PULSE_CYCLES = 4'hF;

endpackage : supervisor_pkg

// ---- logic/windowed_supervisor_timer.sv ----
`timescale 1ns/1ps

module windowed_supervisor_timer (
    input  wire logic                              clock,
    input  wire logic                              rst,
    input  wire logic                              supervisor_tick_clock,
    input  wire logic [supervisor_pkg::ADDR_W-1:0] addr,
    input  wire logic [supervisor_pkg::DATA_W-1:0] wr_data,
    input  wire logic                              wr_en,
    input  wire logic                              rd_en,
    output logic      [supervisor_pkg::DATA_W-1:0] rd_data,
    output logic                                   irq,
    output logic                                   chip_reset
);
    import supervisor_pkg::*;

    function automatic logic [DATA_W-1:0] widen_cnt(input logic [CNT_W-1:0] v);
        widen_cnt = {{(DATA_W-CNT_W){1'b0}}, v};
    endfunction : widen_cnt

    function automatic logic [DATA_W-1:0] widen_stat(input logic [STAT_W-1:0] v);
        widen_stat = {{(DATA_W-STAT_W){1'b0}}, v};
    endfunction : widen_stat

    // The oscillator tick is foreign to the bus clock, so it passes two flops first.
    logic                   tick_meta_q;
    logic                   tick_sync_q;
    logic                   tick_prev_q;
    logic [PRE_W-1:0]       pre_q;
    logic [PRE_W-1:0]       pre_d;
    logic [CNT_W-1:0]       count_q;
    logic [CNT_W-1:0]       count_d;
    logic [CNT_W-1:0]       timeout_q;
    logic [CNT_W-1:0]       timeout_d;
    logic [CNT_W-1:0]       warning_q;
    logic [CNT_W-1:0]       window_q;
    logic                   enable_q;
    logic                   enable_d;
    logic                   rst_sel_q;
    logic                   rst_sel_d;
    logic                   win_en_q;
    logic                   armed_q;
    logic                   armed_d;
    logic [STAT_W-1:0]      status_q;
    logic [STAT_W-1:0]      status_d;
    logic [STAT_W-1:0]      mask_q;
    logic                   cause_q;
    logic                   cause_d;
    logic [RST_PULSE_W-1:0] pulse_q;
    logic [RST_PULSE_W-1:0] pulse_d;

    wire tick_edge = tick_sync_q & ~tick_prev_q;
    wire pre_tick  = tick_edge & enable_q & (pre_q == PRESCALE_LAST);

    wire sel_control = (addr == OFS_CONTROL);
    wire sel_timeout = (addr == OFS_TIMEOUT);
    wire sel_feed    = (addr == OFS_FEED);
    wire sel_count   = (addr == OFS_COUNT);
    wire sel_warning = (addr == OFS_WARNING);
    wire sel_window  = (addr == OFS_WINDOW);
    wire sel_status  = (addr == OFS_STATUS);
    wire sel_mask    = (addr == OFS_MASK);
    wire sel_cause   = (addr == OFS_RST_CAUSE);

    wire wr_control = wr_en & sel_control;
    wire wr_feed    = wr_en & sel_feed;
    wire key_first  = (wr_data == FEED_KEY_FIRST);
    wire key_second = (wr_data == FEED_KEY_SECOND);
    wire any_access = wr_en | rd_en;

    // Reload before the minimum time: the counter is still above the window value.
    wire window_bad = win_en_q & (count_q > window_q);
    wire seq_done   = armed_q & wr_feed & key_second;
    wire seq_broken = (armed_q & any_access & ~(wr_feed & key_second))
                    | (~armed_q & wr_feed & ~key_first);
    wire bad_feed   = enable_q & (seq_broken | (seq_done & window_bad));
    wire good_feed  = enable_q & seq_done & ~window_bad;
    wire expire     = pre_tick & (count_q == '0);
    wire fault      = expire | bad_feed;
    wire warn_hit   = pre_tick & (count_q == warning_q) & (count_q != '0);

    wire [CNT_W-1:0] wr_cnt = wr_data[CNT_W-1:0];
    // Values below the minimum are raised to it so the shortest period stays 256x4 ticks.
    wire [CNT_W-1:0] wr_timeout = (wr_cnt < TIMEOUT_MIN) ? TIMEOUT_MIN : wr_cnt;

    wire [STAT_W-1:0] status_set = {bad_feed & ~rst_sel_q, warn_hit, expire & ~rst_sel_q};
    wire [STAT_W-1:0] status_clr = (wr_en & sel_status) ? wr_data[STAT_W-1:0] : '0;

    wire [DATA_W-1:0] ctrl_view = widen_stat({win_en_q, rst_sel_q, enable_q});
    wire [DATA_W-1:0] rd_mux =
        sel_control ? ctrl_view :
        sel_timeout ? widen_cnt(timeout_q) :
        sel_count   ? widen_cnt(count_q) :
        sel_warning ? widen_cnt(warning_q) :
        sel_window  ? widen_cnt(window_q) :
        sel_status  ? widen_stat(status_q) :
        sel_mask    ? widen_stat(mask_q) :
        sel_cause   ? {{(DATA_W-1){1'b0}}, cause_q} : '0;

    // Enable and reset-select are set-only; a fault drops enable so the next start is clean.
    assign enable_d  = fault ? 1'b0 : (enable_q | (wr_control & wr_data[CTRL_ENABLE_BIT]));
    assign rst_sel_d = rst_sel_q | (wr_control & wr_data[CTRL_RST_SEL_BIT]);
    assign armed_d   = enable_q & ~armed_q & wr_feed & key_first;
    assign pre_d     = tick_edge & enable_q ? pre_q + 1'b1 : pre_q;
    assign timeout_d = (wr_en & sel_timeout) ? wr_timeout : timeout_q;
    assign count_d   = (good_feed | fault) ? timeout_q :
                       pre_tick ? count_q - 1'b1 : count_q;
    assign status_d  = (status_q & ~status_clr) | status_set;
    // A fault in the same cycle as the clear write keeps the flag set.
    assign cause_d   = (cause_q & ~(wr_en & sel_cause & wr_data[0])) | (fault & rst_sel_q);
    assign pulse_d   = (fault & rst_sel_q) ? RST_PULSE_CYCLES :
                       (pulse_q != '0) ? pulse_q - 1'b1 : pulse_q;

    always_ff @(posedge clock) begin
        tick_meta_q <= supervisor_tick_clock;
        tick_sync_q <= tick_meta_q;
        tick_prev_q <= tick_sync_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_q     <= '0;
            count_q   <= TIMEOUT_RESET;
            timeout_q <= TIMEOUT_RESET;
            enable_q  <= 1'b0;
            rst_sel_q <= 1'b0;
            armed_q   <= 1'b0;
        end else begin
            pre_q     <= pre_d;
            count_q   <= count_d;
            timeout_q <= timeout_d;
            enable_q  <= enable_d;
            rst_sel_q <= rst_sel_d;
            armed_q   <= armed_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            warning_q <= WARNING_RESET;
            window_q  <= WINDOW_RESET;
            win_en_q  <= 1'b0;
            mask_q    <= '0;
        end else begin
            if (wr_en & sel_warning) begin
                warning_q <= wr_cnt;
            end
            if (wr_en & sel_window) begin
                window_q <= wr_cnt;
            end
            if (wr_control) begin
                win_en_q <= wr_data[CTRL_WIN_EN_BIT];
            end
            if (wr_en & sel_mask) begin
                mask_q <= wr_data[STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status_q   <= '0;
            cause_q    <= 1'b0;
            pulse_q    <= '0;
            chip_reset <= 1'b0;
            irq        <= 1'b0;
            rd_data    <= '0;
        end else begin
            status_q   <= status_d;
            cause_q    <= cause_d;
            pulse_q    <= pulse_d;
            chip_reset <= (pulse_d != '0);
            irq        <= |(status_d & mask_q);
            rd_data    <= rd_en ? rd_mux : '0;
        end
    end

endmodule : windowed_supervisor_timer

// ---- verif/supervisor_chk.sv ----
`timescale 1ns/1ps
module supervisor_chk import supervisor_pkg::*; (
    input wire logic                              clock,
    input wire logic                              rst,
    input wire logic                              supervisor_tick_clock,
    input wire logic [supervisor_pkg::ADDR_W-1:0] addr,
    input wire logic [supervisor_pkg::DATA_W-1:0] wr_data,
    input wire logic                              wr_en,
    input wire logic                              rd_en,
    input wire logic [supervisor_pkg::DATA_W-1:0] rd_data,
    input wire logic                              irq,
    input wire logic                              chip_reset
);
    logic              rd_q;
    logic [ADDR_W-1:0] ra_q;
    always_ff @(posedge clock) rd_q <= rd_en && !rst;
    always_ff @(posedge clock) ra_q <= addr;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence pulse_s; chip_reset[*8] ##1 chip_reset[*7] ##1 !chip_reset; endsequence
    a_pulse_len: assert property ($rose(chip_reset) |-> pulse_s)
        else $error("reset pulse length wrong");
    a_reset_quiet: assert property ($fell(rst) |-> !chip_reset && !irq)
        else $error("outputs busy after reset");
    a_timeout_floor: assert property (rd_q && ra_q == OFS_TIMEOUT |-> rd_data >= 32'hFF)
        else $error("timeout below floor");
    a_count_width: assert property (rd_q && ra_q == OFS_COUNT |-> rd_data[31:24] == '0)
        else $error("count wider than 24 bits");
    a_feed_wo: assert property (rd_q && ra_q == OFS_FEED |-> rd_data == '0)
        else $error("feed register readable");
    a_ctrl_bits: assert property (rd_q && ra_q == OFS_CONTROL |-> rd_data[31:3] == '0)
        else $error("control upper bits set");
    a_cause_bit: assert property (rd_q && ra_q == OFS_RST_CAUSE |-> rd_data[31:1] == '0)
        else $error("cause upper bits set");
    a_mask_quiet: assert property (wr_en && addr == OFS_MASK && wr_data[2:0] == 3'h0
        |-> ##2 !irq) else $error("irq high with all masked");
    c_pulse: cover property ($rose(chip_reset));
    c_irq: cover property ($rose(irq));
    c_feed: cover property (wr_en && addr == OFS_FEED ##1 wr_en && addr == OFS_FEED);
endmodule : supervisor_chk
bind windowed_supervisor_timer supervisor_chk chk (.clock(clock), .rst(rst),
    .supervisor_tick_clock(supervisor_tick_clock), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .chip_reset(chip_reset));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import supervisor_pkg::*;
    typedef struct packed {logic [1:0] k; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} op_t;
    logic              clock = 0, rst = 1, tick = 0, tick_run = 0, wr_en = 0, rd_en = 0;
    logic              pend = 0, irq, chip_reset;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0, rd_data, lf = 32'h0000_1766, exp_q[$];
    int                err_total = 0, n_compared = 0, t = 0;
    op_t               prog[$] = '{
        '{1, OFS_CONTROL, 32'h0}, '{1, OFS_TIMEOUT, 32'h00FF_FFFF}, '{1, OFS_FEED, 32'h0},
        '{1, 6'h3C, 32'h0}, '{0, OFS_TIMEOUT, 32'h10}, '{1, OFS_TIMEOUT, 32'hFF},
        '{3, 6'h0, 32'h0}, '{0, OFS_MASK, 32'h7}, '{0, OFS_CONTROL, 32'h1},
        '{0, OFS_CONTROL, 32'h0}, '{1, OFS_CONTROL, 32'h1}, '{0, OFS_FEED, FEED_KEY_FIRST},
        '{0, OFS_FEED, FEED_KEY_SECOND}, '{1, OFS_COUNT, 32'hFF},
        '{0, OFS_FEED, FEED_KEY_FIRST}, '{1, OFS_COUNT, 32'hFF}, '{2, 6'h2, 32'h4},
        '{1, OFS_STATUS, 32'h4}, '{1, OFS_CONTROL, 32'h0}, '{0, OFS_STATUS, 32'h4},
        '{2, 6'h0, 32'h4}, '{3, 6'h0, 32'h0}, '{0, OFS_WINDOW, 32'h10},
        '{0, OFS_CONTROL, 32'h5}, '{0, OFS_FEED, FEED_KEY_FIRST},
        '{0, OFS_FEED, FEED_KEY_SECOND}, '{2, 6'h2, 32'h4}, '{1, OFS_STATUS, 32'h4},
        '{0, OFS_STATUS, 32'h7}, '{0, OFS_CONTROL, 32'h0}, '{3, 6'h0, 32'h0},
        '{0, OFS_WARNING, 32'h80}, '{0, OFS_MASK, 32'h2}, '{0, OFS_CONTROL, 32'h1},
        '{0, OFS_FEED, FEED_KEY_FIRST}, '{0, OFS_FEED, FEED_KEY_SECOND},
        '{3, 6'h0, 32'h1}, '{2, 6'h2, 32'h1770}, '{1, OFS_STATUS, 32'h2},
        '{3, 6'h0, 32'h157C}, '{1, OFS_STATUS, 32'h3}, '{1, OFS_CONTROL, 32'h0},
        '{0, OFS_STATUS, 32'h7}, '{3, 6'h0, 32'h0}, '{0, OFS_WARNING, 32'h0},
        '{0, OFS_MASK, 32'h0}, '{0, OFS_CONTROL, 32'h3}, '{0, OFS_FEED, FEED_KEY_FIRST},
        '{0, OFS_FEED, FEED_KEY_SECOND}, '{2, 6'h3, 32'h2AF8}, '{3, 6'h0, 32'h14},
        '{1, OFS_RST_CAUSE, 32'h1}, '{1, OFS_STATUS, 32'h0}, '{0, OFS_RST_CAUSE, 32'h1},
        '{1, OFS_RST_CAUSE, 32'h0}, '{0, OFS_CONTROL, 32'h1}, '{0, OFS_FEED, 32'h33},
        '{2, 6'h3, 32'h8}, '{3, 6'h0, 32'h0}};
    windowed_supervisor_timer dut (.clock(clock), .rst(rst), .supervisor_tick_clock(tick),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .irq(irq), .chip_reset(chip_reset));
    initial forever #4 clock = ~clock;
    always #17 if (tick_run) tick = ~tick;
    function automatic logic [DATA_W-1:0] lfsr(logic [DATA_W-1:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic run(op_t p);
        int   n;
        logic s;
        n = p.d;
        wr_en   <= p.k == 2'd0;
        rd_en   <= p.k == 2'd1;
        addr    <= p.a;
        wr_data <= p.d;
        if (p.k == 2'd1) exp_q.push_back(p.d);
        if (p.k == 2'd2) begin
            do begin
                @(negedge clock);
                n--;
                s = p.a[0] ? chip_reset : irq;
            end while (s !== p.a[1] && n > 0);
            check(p.a[0] ? "chip_reset" : "irq", {31'h0, p.a[1]}, {31'h0, s});
            if (s !== p.a[1]) results();
        end
        if (p.k == 2'd3) begin
            tick_run = tick_run | (n != 0);
            repeat (n) @(posedge clock);
            if (n == 0) $display("test %0d done", t++);
        end
        @(posedge clock);
    endtask : run
    always @(posedge clock) begin
        if (pend) check("rd_data", exp_q.pop_front(), rd_data);
        pend <= rd_en;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        lf = lfsr(lf);
        run('{0, OFS_WINDOW, lf});
        run('{1, OFS_WINDOW, {8'h00, lf[23:0]}});
        foreach (prog[i]) run(prog[i]);
        results();
    end
endmodule : testbench
